// file: inc/arrpwm_pkg.sv
package arrpwm_pkg;
   localparam int NCH = 3;
   // register addresses on the special-function-register bus
   localparam logic [7:0] ADDR_CLR = 8'hce;
   localparam logic [7:0] ADDR_PWM = 8'hf7;
   localparam logic [NCH-1:0][7:0] ADDR_CMP_LO = {8'hed, 8'heb, 8'he9};
   localparam logic [NCH-1:0][7:0] ADDR_CMP_HI = {8'hfd, 8'hfb, 8'hf9};
   // pwm configuration fields
   localparam int PWM_RLD_SEL = 7;
   localparam int PWM_IRQ_EN = 6;
   localparam int PWM_OVF = 5;
   localparam int PWM_LEN_LSB = 0;
   localparam int PWM_LEN_W = 2;
   // comparator clear fields
   localparam int CLR_POL = 7;
   localparam int CLR_RSVD_LSB = 3;
   localparam int CLR_RSVD_W = 4;
   localparam int CLR_EN_LSB = 0;
   localparam logic [7:0] RST_PWM = 8'h00;
   localparam logic [7:0] RST_CLR = 8'h00;
   localparam logic [7:0] RD_NONE = 8'h00;
   localparam logic [2:0] RD_UNUSED = 3'h0;
   // cycle lengths
   localparam logic [1:0] LEN_8 = 2'h0;
   localparam logic [1:0] LEN_9 = 2'h1;
   localparam logic [1:0] LEN_10 = 2'h2;
   localparam logic [1:0] LEN_11 = 2'h3;
   localparam logic [15:0] MASK_8 = 16'h00ff;
   localparam logic [15:0] MASK_9 = 16'h01ff;
   localparam logic [15:0] MASK_10 = 16'h03ff;
   localparam logic [15:0] MASK_11 = 16'h07ff;
   localparam logic [15:0] MASK_16 = 16'hffff;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } arrpwm_sfr_t;

   typedef struct packed {
      logic [15:0] value;
      logic tick;
   } arrpwm_cnt_t;

   typedef struct packed {
      logic [NCH-1:0] pwm_en;
      logic [NCH-1:0] wide;
   } arrpwm_chcfg_t;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] sync;
      logic last;
   } arrpwm_edge_st_t;

   typedef struct packed {
      logic reload_sel;
      logic ovf_irq_en;
      logic ovf_flag;
      logic [PWM_LEN_W-1:0] len_sel;
      logic clr_pol;
      logic [CLR_RSVD_W-1:0] clr_rsvd;
      logic [NCH-1:0] clr_en;
      logic [NCH-1:0][15:0] cmp;
      logic [NCH-1:0][15:0] rld;
      logic [NCH-1:0][15:0] eff;
      logic [NCH-1:0] pin;
      logic [NCH-1:0] hold_clr;
      logic [7:0] rdata;
      logic irq;
   } arrpwm_state_t;
endpackage : arrpwm_pkg

// file: src/arrpwm_edge.sv
`timescale 1ns/100ps
`default_nettype none
module arrpwm_edge (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic level_i,
   output logic rise_o,
   output logic fall_o
);
   import arrpwm_pkg::*;

   arrpwm_edge_st_t st_r;
   arrpwm_edge_st_t st_nxt;

   // the first stage feeds only the second; edges look at stage two and later
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync = {st_r.sync[0], level_i};
      st_nxt.last = st_r.sync[1];
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rise_o = st_r.sync[1] & ~st_r.last;
   assign fall_o = ~st_r.sync[1] & st_r.last;
endmodule : arrpwm_edge
`default_nettype wire

// file: src/arrpwm_top.sv
// Operation
// - select bit routes compare addresses to reload
// - reload registers matter only for 9-11 bit
// - overflow flag interrupts only while enabled
// - flag set on selected counter bit overflow
// - flag set by hardware or software, software clears
// - length field picks 8, 9, 10, 11 bits
// - length shared by non-wide pwm channels
// - unused pwm bits read zero, writes ignored
// - polarity picks falling or rising comparator clear
// - low three bits enable clear per channel
// - pwm mode channel drives waveform on pin
// - wide select chooses 16-bit period
`timescale 1ns/100ps
`default_nettype none
module arrpwm_top (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire arrpwm_pkg::arrpwm_sfr_t sfr_i,
   input wire arrpwm_pkg::arrpwm_cnt_t main_array_counter_i,
   input wire arrpwm_pkg::arrpwm_chcfg_t chcfg_i,
   input wire logic cmp_result_i,
   output logic [7:0] sfr_rdata_o,
   output logic irq_o,
   output logic [arrpwm_pkg::NCH-1:0] channel_output_pin_o
);
   import arrpwm_pkg::*;

   arrpwm_state_t st_r;
   arrpwm_state_t st_nxt;
   logic cmp_rise;
   logic cmp_fall;
   logic clr_evt;
   logic short_end;
   logic full_end;
   logic wr_pwm;
   logic wr_clr;
   logic [15:0] len_mask;

   function automatic logic [15:0] cycle_mask(input logic [1:0] sel);
      case (sel)
         LEN_8: cycle_mask = MASK_8;
         LEN_9: cycle_mask = MASK_9;
         LEN_10: cycle_mask = MASK_10;
         LEN_11: cycle_mask = MASK_11;
         default: cycle_mask = MASK_8;
      endcase
   endfunction : cycle_mask

   // counter about to carry out of the masked bits on this tick
   function automatic logic wraps(input arrpwm_cnt_t c, input logic [15:0] m);
      wraps = c.tick && ((c.value & m) == m);
   endfunction : wraps

   arrpwm_edge u_edge (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .level_i(cmp_result_i),
      .rise_o(cmp_rise),
      .fall_o(cmp_fall)
   );

   assign clr_evt = st_r.clr_pol ? cmp_rise : cmp_fall;
   assign len_mask = cycle_mask(st_r.len_sel);
   assign short_end = wraps(main_array_counter_i, len_mask);
   assign full_end = wraps(main_array_counter_i, MASK_16);
   // fixed addresses: no page decode, so every page reaches them
   assign wr_pwm = sfr_i.wr && (sfr_i.addr == ADDR_PWM);
   assign wr_clr = sfr_i.wr && (sfr_i.addr == ADDR_CLR);

   always_comb begin
      logic [15:0] m;
      logic cyc_end;
      m = MASK_16;
      cyc_end = 1'b0;
      st_nxt = st_r;

      if (wr_pwm) begin
         st_nxt.reload_sel = sfr_i.wdata[PWM_RLD_SEL];
         st_nxt.ovf_irq_en = sfr_i.wdata[PWM_IRQ_EN];
         st_nxt.len_sel = sfr_i.wdata[PWM_LEN_LSB +: PWM_LEN_W];
         // bits 4:2 have no storage, so writes there vanish
      end
      // set wins over a clearing write in the same cycle
      st_nxt.ovf_flag = short_end | (wr_pwm ? sfr_i.wdata[PWM_OVF] : st_r.ovf_flag);

      if (wr_clr) begin
         st_nxt.clr_pol = sfr_i.wdata[CLR_POL];
         st_nxt.clr_rsvd = sfr_i.wdata[CLR_RSVD_LSB +: CLR_RSVD_W];
         st_nxt.clr_en = sfr_i.wdata[CLR_EN_LSB +: NCH];
      end

      for (int i = 0; i < NCH; i++) begin
         if (sfr_i.wr && (sfr_i.addr == ADDR_CMP_LO[i])) begin
            if (st_r.reload_sel) begin
               st_nxt.rld[i][7:0] = sfr_i.wdata;
            end else begin
               st_nxt.cmp[i][7:0] = sfr_i.wdata;
            end
         end
         if (sfr_i.wr && (sfr_i.addr == ADDR_CMP_HI[i])) begin
            if (st_r.reload_sel) begin
               st_nxt.rld[i][15:8] = sfr_i.wdata;
            end else begin
               st_nxt.cmp[i][15:8] = sfr_i.wdata;
            end
         end

         // wide channels ignore the shared length
         m = chcfg_i.wide[i] ? MASK_16 : len_mask;
         cyc_end = chcfg_i.wide[i] ? full_end : short_end;
         if (cyc_end) begin
            st_nxt.hold_clr[i] = 1'b0;
            if (chcfg_i.wide[i]) begin
               st_nxt.eff[i] = st_r.cmp[i];
            end else if (st_r.len_sel == LEN_8) begin
               st_nxt.eff[i] = {8'h00, st_r.cmp[i][15:8]};
            end else begin
               st_nxt.eff[i] = st_r.rld[i] & len_mask;
            end
         end
         if (clr_evt && st_r.clr_en[i]) begin
            st_nxt.hold_clr[i] = 1'b1;
         end
         // high while the cycle position is below the compare value
         st_nxt.pin[i] = chcfg_i.pwm_en[i] && !st_nxt.hold_clr[i] &&
                         ((main_array_counter_i.value & m) < (st_nxt.eff[i] & m));
      end

      st_nxt.rdata = st_r.rdata;
      if (sfr_i.rd) begin
         st_nxt.rdata = RD_NONE;
         if (sfr_i.addr == ADDR_PWM) begin
            st_nxt.rdata = {st_r.reload_sel, st_r.ovf_irq_en, st_r.ovf_flag, RD_UNUSED, st_r.len_sel};
         end
         if (sfr_i.addr == ADDR_CLR) begin
            st_nxt.rdata = {st_r.clr_pol, st_r.clr_rsvd, st_r.clr_en};
         end
         for (int i = 0; i < NCH; i++) begin
            if (sfr_i.addr == ADDR_CMP_LO[i]) begin
               st_nxt.rdata = st_r.reload_sel ? st_r.rld[i][7:0] : st_r.cmp[i][7:0];
            end
            if (sfr_i.addr == ADDR_CMP_HI[i]) begin
               st_nxt.rdata = st_r.reload_sel ? st_r.rld[i][15:8] : st_r.cmp[i][15:8];
            end
         end
      end

      st_nxt.irq = st_nxt.ovf_flag && st_nxt.ovf_irq_en;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sfr_rdata_o = st_r.rdata;
   assign irq_o = st_r.irq;
   assign channel_output_pin_o = st_r.pin;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_unused_zero;
      sfr_i.rd && (sfr_i.addr == ADDR_PWM) |=> (sfr_rdata_o[4:2] == RD_UNUSED);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused pwm bits read nonzero");

   property p_irq_raise;
      $rose(st_r.ovf_flag) && st_r.ovf_irq_en && !wr_pwm |-> irq_o;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("enabled overflow flag gave no request");

   property p_irq_masked;
      !st_r.ovf_irq_en |-> !irq_o;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked overflow flag gave request");

   property p_ovf_set;
      short_end |=> st_r.ovf_flag;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow did not set flag");

   property p_flag_sticky;
      st_r.ovf_flag && !wr_pwm |=> st_r.ovf_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without software");

   property p_len9;
      (st_r.len_sel == LEN_9) && main_array_counter_i.tick &&
      (main_array_counter_i.value[8:0] == 9'h1ff) |-> short_end;
   endproperty
   a_len9: assert property (p_len9) else $error("9-bit cycle end missed");

   property p_route_reload;
      sfr_i.wr && (sfr_i.addr == ADDR_CMP_LO[0]) && st_r.reload_sel |=>
         (st_r.rld[0][7:0] == $past(sfr_i.wdata)) && (st_r.cmp[0] == $past(st_r.cmp[0]));
   endproperty
   a_route_reload: assert property (p_route_reload) else $error("reload select did not route write");

   generate
      for (genvar g = 0; g < NCH; g++) begin : g_chk
         property p_clear_hold;
            clr_evt && st_r.clr_en[g] |=> !channel_output_pin_o[g];
         endproperty
         a_clear_hold: assert property (p_clear_hold) else $error("comparator clear left output high");

         property p_idle_low;
            !chcfg_i.pwm_en[g] |=> !channel_output_pin_o[g];
         endproperty
         a_idle_low: assert property (p_idle_low) else $error("non-pwm channel drove output");

         property p_wide_load;
            chcfg_i.wide[g] && full_end |=> (st_r.eff[g] == $past(st_r.cmp[g]));
         endproperty
         a_wide_load: assert property (p_wide_load) else $error("wide channel did not load full value");

         property p_reload_use;
            !chcfg_i.wide[g] && (st_r.len_sel != LEN_8) && short_end |=>
               (st_r.eff[g] == ($past(st_r.rld[g]) & $past(len_mask)));
         endproperty
         a_reload_use: assert property (p_reload_use) else $error("reload value not applied");
      end
   endgenerate

   c_irq: cover property (irq_o);
   c_clear: cover property (clr_evt && (st_r.clr_en != '0));
   c_len11: cover property ((st_r.len_sel == LEN_11) && short_end);
endmodule : arrpwm_top
`default_nettype wire

// file: tb/arrpwm_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module arrpwm_cpu_model (
   input wire logic clk_i,
   output var arrpwm_pkg::arrpwm_sfr_t sfr_o
);
   import arrpwm_pkg::*;
   logic [7:0] exp_q[$];
   initial sfr_o = '0;
   // software clears the flag by writing 0 to it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      sfr_o <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: (a == ADDR_CLR) ? (d & 8'h87) : d};
      @(negedge clk_i);
      sfr_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(negedge clk_i);
      sfr_o <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: sfr_o.wdata};
      @(negedge clk_i);
      sfr_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~sfr_o.wdata};
   endtask : rd
endmodule : arrpwm_cpu_model
`default_nettype wire

// file: tb/arrpwm_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module arrpwm_tb_top;
   import arrpwm_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic cmp_r = 1'b0;
   logic rd_seen = 1'b0;
   logic irq;
   logic [7:0] rdata;
   logic [7:0] ev;
   logic [2:0] pin;
   logic [15:0] mask;
   logic [15:0] cmpv[3] = '{16'h4000, 16'h8000, 16'hc000};
   logic [15:0] rldv[3] = '{16'h0100, 16'h0180, 16'h0000};
   arrpwm_sfr_t sfr;
   arrpwm_cnt_t cnt = '{value: 16'h0000, tick: 1'b1};
   arrpwm_chcfg_t chcfg = '{pwm_en: 3'h7, wide: 3'h4};
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   always #5 clk_i = ~clk_i;
   arrpwm_cpu_model u_cpu (.clk_i(clk_i), .sfr_o(sfr));
   arrpwm_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_i(sfr), .main_array_counter_i(cnt),
      .chcfg_i(chcfg), .cmp_result_i(cmp_r), .sfr_rdata_o(rdata), .irq_o(irq), .channel_output_pin_o(pin));
   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // read results are compared half a cycle after the strobe is taken
   always @(posedge clk_i) rd_seen <= sfr.rd;
   always @(negedge clk_i) begin
      if (rd_seen) begin
         ev = u_cpu.exp_q.pop_front();
         `CHK(rdata, ev)
      end
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 10000) begin
         num_errors++;
         report_and_stop();
      end
   end
   // exp of 0 means the channel was cut short by a comparator clear
   task automatic run_pass(input logic [1:0] len, input logic [7:0] clr, input logic lvl, input int e0, e1);
      int n[3];
      int per;
      int ex[2];
      per = 256 << len;
      ex = '{e0, e1};
      n = '{0, 0, 0};
      u_cpu.wr(ADDR_PWM, {6'h00, len});
      u_cpu.wr(ADDR_CLR, clr);
      cmp_r = lvl;
      cnt.value = 16'hffe0;
      for (int i = 0; i < per + 32; i++) begin
         @(negedge clk_i);
         cnt.value <= cnt.value + 16'h0001;
         if (i == 48) cmp_r = ~lvl;
         if (i >= 32) for (int j = 0; j < 3; j++) n[j] += int'(pin[j]);
      end
      for (int j = 0; j < 2; j++) begin
         if (ex[j] == 0) `CHK(n[j] < 32, 1'b1)
         else `CHK(n[j], ex[j])
      end
      `CHK(n[2], per)
   endtask : run_pass
   initial begin
      void'($urandom(8));
      repeat (2) @(negedge clk_i);
      arst_n_i = 1'b1;
      u_cpu.rd(ADDR_PWM, RST_PWM);
      u_cpu.rd(ADDR_CLR, RST_CLR);
      u_cpu.rd(8'h00, RD_NONE);
      u_cpu.wr(ADDR_PWM, 8'hff);
      @(negedge clk_i);
      `CHK(irq, 1'b1)
      u_cpu.rd(ADDR_PWM, 8'he3);
      u_cpu.wr(ADDR_PWM, 8'h20);
      @(negedge clk_i);
      `CHK(irq, 1'b0)
      u_cpu.wr(ADDR_CLR, 8'hff);
      u_cpu.rd(ADDR_CLR, 8'h87);
      for (int k = 0; k < 4; k++) begin
         mask = (16'h0100 << k) - 16'h0001;
         // counter stays at zero during the write, so the old length cannot wrap
         u_cpu.wr(ADDR_PWM, 8'(k));
         cnt.value = (16'($urandom) & ~mask) | (mask >> 1);
         u_cpu.rd(ADDR_PWM, 8'(k));
         // a full count without a tick must not set the flag
         cnt.tick = 1'b0;
         cnt.value = cnt.value | mask;
         u_cpu.rd(ADDR_PWM, 8'(k));
         cnt.tick = 1'b1;
         u_cpu.rd(ADDR_PWM, 8'h20 | 8'(k));
         `CHK(irq, 1'b0)
         cnt.value = 16'h0000;
      end
      for (int c = 0; c < 3; c++) begin
         u_cpu.wr(ADDR_PWM, 8'h00);
         u_cpu.wr(ADDR_CMP_LO[c], cmpv[c][7:0]);
         u_cpu.wr(ADDR_CMP_HI[c], cmpv[c][15:8]);
         u_cpu.wr(ADDR_PWM, 8'h80);
         u_cpu.wr(ADDR_CMP_LO[c], rldv[c][7:0]);
         u_cpu.wr(ADDR_CMP_HI[c], rldv[c][15:8]);
         u_cpu.rd(ADDR_CMP_HI[c], rldv[c][15:8]);
         u_cpu.rd(ADDR_CMP_LO[c], rldv[c][7:0]);
         u_cpu.wr(ADDR_PWM, 8'h00);
         u_cpu.rd(ADDR_CMP_HI[c], cmpv[c][15:8]);
      end
      run_pass(2'h0, 8'h00, 1'b0, 'h40, 'h80);
      run_pass(2'h1, 8'h00, 1'b0, 'h100, 'h180);
      run_pass(2'h0, 8'h81, 1'b0, 0, 'h80);
      run_pass(2'h0, 8'h02, 1'b1, 'h40, 0);
      // counter now sits where every channel would be high in pwm mode
      chcfg.pwm_en = 3'h0;
      repeat (2) @(negedge clk_i);
      `CHK(pin, 3'h0)
      report_and_stop();
   end
endmodule : arrpwm_tb_top
`default_nettype wire
